/* File: include/oiu_pkg.sv */
// Constants, codes and state encodings for the operand interpretation unit
`default_nettype none
package oiu_pkg;
	localparam int WORD_W = 30;
	localparam int HALF_W = 15;
	localparam int FUNC_W = 6;
	localparam int COND_W = 3;
	localparam int KDES_W = 3;
	localparam int BDES_W = 3;
	localparam int IDX_N = 8;

	// Field positions inside the instruction word
	localparam int FUNC_LSB = 24;
	localparam int COND_LSB = 21;
	localparam int KDES_LSB = 18;
	localparam int BDES_LSB = 15;
	localparam int ADDR_LSB = 0;

	// Function codes (octal 00, 77, 14-17, 32-37, 24-25, 40-57)
	localparam logic [5:0] FUNC_FAULT_LO = 6'h00;
	localparam logic [5:0] FUNC_FAULT_HI = 6'h3f;
	localparam logic [5:0] FUNC_STORE_LO = 6'h0c;
	localparam logic [5:0] FUNC_STORE_HI = 6'h0f;
	localparam logic [5:0] FUNC_ADD_REPL_LO = 6'h14;
	localparam logic [5:0] FUNC_ADD_REPL_HI = 6'h15;
	localparam logic [5:0] FUNC_QSTORE_LO = 6'h1a;
	localparam logic [5:0] FUNC_QSTORE_HI = 6'h1b;
	localparam logic [5:0] FUNC_QREPL_LO = 6'h1c;
	localparam logic [5:0] FUNC_QREPL_HI = 6'h1f;
	localparam logic [5:0] FUNC_LP_LO = 6'h20;
	localparam logic [5:0] FUNC_LP_REPL_LO = 6'h24;
	localparam logic [5:0] FUNC_LP_REPL_HI = 6'h26;
	localparam logic [5:0] FUNC_LP_STORE = 6'h27;
	localparam logic [5:0] FUNC_SEL_LO = 6'h28;
	localparam logic [5:0] FUNC_SEL_REPL_LO = 6'h2c;
	localparam logic [5:0] FUNC_SEL_HI = 6'h2f;

	// Operand interpretation values
	localparam logic [2:0] K_IMM = 3'h0;
	localparam logic [2:0] K_LOW = 3'h1;
	localparam logic [2:0] K_HIGH = 3'h2;
	localparam logic [2:0] K_FULL = 3'h3;
	localparam logic [2:0] K_IMM_SX = 3'h4;
	localparam logic [2:0] K_LOW_SX = 3'h5;
	localparam logic [2:0] K_HIGH_SX = 3'h6;
	localparam logic [2:0] K_ACC = 3'h7;

	localparam logic [2:0] BDES_NONE = 3'h0;
	localparam logic [29:0] WORD_RST = 30'h0;
	localparam logic [14:0] HALF_RST = 15'h0;
	localparam logic [14:0] HALF_ONES = 15'h7fff;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_MODIFY = 4'h1,
		ST_DISPATCH = 4'h2,
		ST_MEM_RD = 4'h3,
		ST_EXEC = 4'h4,
		ST_MEM_WR = 4'h5,
		ST_FAULT = 4'h6
	} oiu_state_t;

	typedef enum logic [1:0] {
		CLS_READ = 2'h0,
		CLS_STORE = 2'h1,
		CLS_REPLACE = 2'h2,
		CLS_FAULT = 2'h3
	} oiu_class_t;
endpackage
`default_nettype wire

/* File: verilog/oiu_oc_adder.sv */
// Fifteen-bit ones' complement adder with end-around carry
`timescale 1ns/1ps
`default_nettype none
module oiu_oc_adder (
	input wire logic [14:0] a_i,
	input wire logic [14:0] b_i,
	output logic [14:0] sum_o
);
	logic [15:0] raw;

	assign raw = {1'b0, a_i} + {1'b0, b_i};
	// End-around carry; raw never reaches 16'hffff, so no second carry
	assign sum_o = raw[14:0] + {14'h0, raw[15]};
endmodule
`default_nettype wire

/* File: verilog/oiu_top.sv */
// Operand interpretation unit: classifies, modifies address, steers operands
`timescale 1ns/1ps
`default_nettype none
module oiu_top (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [29:0] instr_i,
	input wire logic [29:0] store_data_i,
	input wire logic [29:0] acc_i,
	input wire logic wb_valid_i,
	input wire logic [29:0] wb_data_i,
	input wire logic idx_wr_i,
	input wire logic [2:0] idx_sel_i,
	input wire logic [14:0] idx_data_i,
	input wire logic fault_clr_i,
	input wire logic mem_ack_i,
	input wire logic [29:0] mem_rdata_i,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [14:0] mem_addr_o,
	output logic [29:0] mem_wdata_o,
	output logic [29:0] operand_o,
	output logic operand_valid_o,
	output logic acc_wr_o,
	output logic [29:0] acc_data_o,
	output logic aux_wr_o,
	output logic [29:0] aux_data_o,
	output logic [1:0] class_o,
	output logic [2:0] cond_o,
	output logic logic_prod_o,
	output logic selective_o,
	output logic busy_o,
	output logic done_o,
	output logic fault_o
);
	typedef struct packed {
		oiu_pkg::oiu_state_t st;
		oiu_pkg::oiu_class_t cls;
		logic [29:0] u;
		logic [29:0] z;
		logic [29:0] x;
		logic [7:0][14:0] idx;
		logic mem_req;
		logic mem_we;
		logic [14:0] mem_addr;
		logic [29:0] mem_wdata;
		logic [29:0] operand;
		logic operand_valid;
		logic acc_wr;
		logic [29:0] acc_data;
		logic aux_wr;
		logic [29:0] aux_data;
		logic logic_prod;
		logic selective;
		logic busy;
		logic done;
		logic fault;
	} oiu_regs_t;

	oiu_regs_t cur_ff;
	oiu_regs_t nxt_regs;
	logic [14:0] mod_sum;
	logic [2:0] cur_k;
	logic [2:0] cur_b;
	logic [5:0] in_func;

	assign cur_k = cur_ff.u[oiu_pkg::KDES_LSB +: oiu_pkg::KDES_W];
	assign cur_b = cur_ff.u[oiu_pkg::BDES_LSB +: oiu_pkg::BDES_W];
	assign in_func = instr_i[oiu_pkg::FUNC_LSB +: oiu_pkg::FUNC_W];

	oiu_oc_adder u_adder (
		.a_i(cur_ff.u[oiu_pkg::ADDR_LSB +: oiu_pkg::HALF_W]),
		.b_i(cur_ff.idx[cur_b]),
		.sum_o(mod_sum)
	);

	function automatic oiu_pkg::oiu_class_t classify(input logic [5:0] f);
		oiu_pkg::oiu_class_t c;
		c = oiu_pkg::CLS_READ;
		if (f == oiu_pkg::FUNC_FAULT_LO || f == oiu_pkg::FUNC_FAULT_HI) begin
			c = oiu_pkg::CLS_FAULT;
		end else if ((f >= oiu_pkg::FUNC_STORE_LO && f <= oiu_pkg::FUNC_STORE_HI)
			|| (f >= oiu_pkg::FUNC_QSTORE_LO && f <= oiu_pkg::FUNC_QSTORE_HI)
			|| f == oiu_pkg::FUNC_LP_STORE) begin
			c = oiu_pkg::CLS_STORE;
		end else if ((f >= oiu_pkg::FUNC_ADD_REPL_LO && f <= oiu_pkg::FUNC_ADD_REPL_HI)
			|| (f >= oiu_pkg::FUNC_QREPL_LO && f <= oiu_pkg::FUNC_QREPL_HI)
			|| (f >= oiu_pkg::FUNC_LP_REPL_LO && f <= oiu_pkg::FUNC_LP_REPL_HI)
			|| (f >= oiu_pkg::FUNC_SEL_REPL_LO && f <= oiu_pkg::FUNC_SEL_HI)) begin
			c = oiu_pkg::CLS_REPLACE;
		end
		return c;
	endfunction

	function automatic logic no_storage_ref(input logic [2:0] k);
		return k == oiu_pkg::K_IMM || k == oiu_pkg::K_IMM_SX || k == oiu_pkg::K_ACC;
	endfunction

	// Read-side transfer into the exchange register
	function automatic logic [29:0] form_operand(
		input logic [2:0] k,
		input logic [14:0] y,
		input logic [29:0] z,
		input logic [29:0] acc
	);
		logic [14:0] half;
		logic [29:0] res;
		half = oiu_pkg::HALF_RST;
		res = oiu_pkg::WORD_RST;
		case (k)
			oiu_pkg::K_IMM, oiu_pkg::K_IMM_SX: begin
				half = y;
			end
			oiu_pkg::K_LOW, oiu_pkg::K_LOW_SX: begin
				half = z[14:0];
			end
			oiu_pkg::K_HIGH, oiu_pkg::K_HIGH_SX: begin
				half = z[29:15];
			end
			default: begin
				half = oiu_pkg::HALF_RST;
			end
		endcase
		if (k == oiu_pkg::K_FULL) begin
			res = z;
		end else if (k == oiu_pkg::K_ACC) begin
			res = acc;
		end else if (k[2] && half[14]) begin
			res = {oiu_pkg::HALF_ONES, half};
		end else begin
			res = {oiu_pkg::HALF_RST, half};
		end
		return res;
	endfunction

	// Write-side merge of exchange value into the stored word
	function automatic logic [29:0] merge_word(
		input logic [2:0] k,
		input logic [29:0] z,
		input logic [29:0] x,
		input logic repl
	);
		logic [29:0] res;
		logic [14:0] low;
		res = z;
		low = (k[2] && !repl) ? ~x[14:0] : x[14:0];
		case (k)
			oiu_pkg::K_LOW, oiu_pkg::K_LOW_SX: begin
				res = {z[29:15], low};
			end
			// High half write keeps low half
			oiu_pkg::K_HIGH, oiu_pkg::K_HIGH_SX: begin
				res = {low, z[14:0]};
			end
			oiu_pkg::K_FULL: begin
				res = x;
			end
			oiu_pkg::K_ACC: begin
				res = ~x;
			end
			default: begin
				res = z;
			end
		endcase
		return res;
	endfunction

	always_comb begin
		nxt_regs = cur_ff;
		nxt_regs.operand_valid = 1'b0;
		nxt_regs.done = 1'b0;
		nxt_regs.acc_wr = 1'b0;
		nxt_regs.aux_wr = 1'b0;
		if (idx_wr_i && idx_sel_i != oiu_pkg::BDES_NONE) begin
			nxt_regs.idx[idx_sel_i] = idx_data_i;
		end
		case (cur_ff.st)
			oiu_pkg::ST_IDLE: begin
				if (start_i) begin
					nxt_regs.u = instr_i;
					nxt_regs.x = store_data_i;
					nxt_regs.z = oiu_pkg::WORD_RST;
					nxt_regs.cls = classify(in_func);
					nxt_regs.logic_prod = in_func >= oiu_pkg::FUNC_LP_LO
						&& in_func <= oiu_pkg::FUNC_LP_STORE;
					nxt_regs.selective = in_func >= oiu_pkg::FUNC_SEL_LO
						&& in_func <= oiu_pkg::FUNC_SEL_HI;
					nxt_regs.busy = 1'b1;
					if (instr_i[oiu_pkg::BDES_LSB +: oiu_pkg::BDES_W] != oiu_pkg::BDES_NONE) begin
						nxt_regs.st = oiu_pkg::ST_MODIFY;
					end else begin
						nxt_regs.st = oiu_pkg::ST_DISPATCH;
					end
				end
			end
			oiu_pkg::ST_MODIFY: begin
				nxt_regs.u[oiu_pkg::ADDR_LSB +: oiu_pkg::HALF_W] = mod_sum;
				nxt_regs.st = oiu_pkg::ST_DISPATCH;
			end
			oiu_pkg::ST_DISPATCH: begin
				nxt_regs.mem_addr = cur_ff.u[oiu_pkg::ADDR_LSB +: oiu_pkg::HALF_W];
				case (cur_ff.cls)
					oiu_pkg::CLS_FAULT: begin
						nxt_regs.fault = 1'b1;
						nxt_regs.st = oiu_pkg::ST_FAULT;
					end
					oiu_pkg::CLS_STORE: begin
						if (cur_k == oiu_pkg::K_IMM) begin
							nxt_regs.aux_wr = 1'b1;
							nxt_regs.aux_data = cur_ff.x;
							nxt_regs.done = 1'b1;
							nxt_regs.busy = 1'b0;
							nxt_regs.st = oiu_pkg::ST_IDLE;
						end else if (cur_k == oiu_pkg::K_IMM_SX) begin
							nxt_regs.acc_wr = 1'b1;
							nxt_regs.acc_data = cur_ff.x;
							nxt_regs.done = 1'b1;
							nxt_regs.busy = 1'b0;
							nxt_regs.st = oiu_pkg::ST_IDLE;
						end else if (cur_k == oiu_pkg::K_FULL || cur_k == oiu_pkg::K_ACC) begin
							// Full word needs no prior read
							nxt_regs.mem_req = 1'b1;
							nxt_regs.mem_we = 1'b1;
							nxt_regs.mem_wdata = merge_word(cur_k, oiu_pkg::WORD_RST,
								cur_ff.x, 1'b0);
							nxt_regs.st = oiu_pkg::ST_MEM_WR;
						end else begin
							// Half writes fetch the word to keep
							nxt_regs.mem_req = 1'b1;
							nxt_regs.mem_we = 1'b0;
							nxt_regs.st = oiu_pkg::ST_MEM_RD;
						end
					end
					default: begin
						if (no_storage_ref(cur_k)) begin
							nxt_regs.x = form_operand(cur_k,
								cur_ff.u[oiu_pkg::ADDR_LSB +: oiu_pkg::HALF_W],
								oiu_pkg::WORD_RST, acc_i);
							nxt_regs.operand = nxt_regs.x;
							nxt_regs.operand_valid = 1'b1;
							if (cur_ff.cls == oiu_pkg::CLS_REPLACE) begin
								nxt_regs.st = oiu_pkg::ST_EXEC;
							end else begin
								nxt_regs.done = 1'b1;
								nxt_regs.busy = 1'b0;
								nxt_regs.st = oiu_pkg::ST_IDLE;
							end
						end else begin
							nxt_regs.mem_req = 1'b1;
							nxt_regs.mem_we = 1'b0;
							nxt_regs.st = oiu_pkg::ST_MEM_RD;
						end
					end
				endcase
			end
			oiu_pkg::ST_MEM_RD: begin
				if (mem_ack_i) begin
					nxt_regs.z = mem_rdata_i;
					if (cur_ff.cls == oiu_pkg::CLS_STORE) begin
						nxt_regs.mem_we = 1'b1;
						nxt_regs.mem_wdata = merge_word(cur_k, mem_rdata_i, cur_ff.x, 1'b0);
						nxt_regs.st = oiu_pkg::ST_MEM_WR;
					end else begin
						nxt_regs.mem_req = 1'b0;
						nxt_regs.x = form_operand(cur_k, oiu_pkg::HALF_RST, mem_rdata_i, acc_i);
						nxt_regs.operand = nxt_regs.x;
						nxt_regs.operand_valid = 1'b1;
						if (cur_ff.cls == oiu_pkg::CLS_REPLACE) begin
							nxt_regs.st = oiu_pkg::ST_EXEC;
						end else begin
							nxt_regs.done = 1'b1;
							nxt_regs.busy = 1'b0;
							nxt_regs.st = oiu_pkg::ST_IDLE;
						end
					end
				end
			end
			oiu_pkg::ST_EXEC: begin
				if (wb_valid_i) begin
					nxt_regs.x = wb_data_i;
					if (no_storage_ref(cur_k)) begin
						nxt_regs.done = 1'b1;
						nxt_regs.busy = 1'b0;
						nxt_regs.st = oiu_pkg::ST_IDLE;
					end else begin
						nxt_regs.mem_req = 1'b1;
						nxt_regs.mem_we = 1'b1;
						nxt_regs.mem_wdata = merge_word(cur_k, cur_ff.z, wb_data_i, 1'b1);
						nxt_regs.st = oiu_pkg::ST_MEM_WR;
					end
				end
			end
			oiu_pkg::ST_MEM_WR: begin
				if (mem_ack_i) begin
					nxt_regs.mem_req = 1'b0;
					nxt_regs.mem_we = 1'b0;
					nxt_regs.done = 1'b1;
					nxt_regs.busy = 1'b0;
					nxt_regs.st = oiu_pkg::ST_IDLE;
				end
			end
			oiu_pkg::ST_FAULT: begin
				if (fault_clr_i) begin
					nxt_regs.fault = 1'b0;
					nxt_regs.busy = 1'b0;
					nxt_regs.st = oiu_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_regs.st = oiu_pkg::ST_IDLE;
				nxt_regs.busy = 1'b0;
				nxt_regs.mem_req = 1'b0;
				nxt_regs.mem_we = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_regs;
		end
	end

	assign mem_req_o = cur_ff.mem_req;
	assign mem_we_o = cur_ff.mem_we;
	assign mem_addr_o = cur_ff.mem_addr;
	assign mem_wdata_o = cur_ff.mem_wdata;
	assign operand_o = cur_ff.operand;
	assign operand_valid_o = cur_ff.operand_valid;
	assign acc_wr_o = cur_ff.acc_wr;
	assign acc_data_o = cur_ff.acc_data;
	assign aux_wr_o = cur_ff.aux_wr;
	assign aux_data_o = cur_ff.aux_data;
	assign class_o = cur_ff.cls;
	assign cond_o = cur_ff.u[oiu_pkg::COND_LSB +: oiu_pkg::COND_W];
	assign logic_prod_o = cur_ff.logic_prod;
	assign selective_o = cur_ff.selective;
	assign busy_o = cur_ff.busy;
	assign done_o = cur_ff.done;
	assign fault_o = cur_ff.fault;
endmodule
`default_nettype wire

/* File: tb/oiu_top_assertions.sv */
// Port-level checks for the operand interpretation unit
`timescale 1ns/1ps
`default_nettype none
module oiu_top_assertions (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [29:0] instr_i,
	input wire logic [29:0] store_data_i,
	input wire logic [29:0] acc_i,
	input wire logic mem_ack_i,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [14:0] mem_addr_o,
	input wire logic [29:0] mem_wdata_o,
	input wire logic [29:0] operand_o,
	input wire logic operand_valid_o,
	input wire logic acc_wr_o,
	input wire logic [29:0] acc_data_o,
	input wire logic [1:0] class_o,
	input wire logic logic_prod_o,
	input wire logic selective_o,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic fault_o
);
	logic take, rd, st;
	logic [5:0] fc;
	logic [2:0] kd;
	assign take = start_i && !busy_o;
	assign fc = instr_i[29:24];
	assign kd = instr_i[20:18];
	// Unmodified read and store forms
	assign rd = take && fc inside {[6'h01:6'h0b]} && instr_i[17:15] == 3'h0;
	assign st = take && fc inside {[6'h0c:6'h0f]} && instr_i[17:15] == 3'h0;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	property p_fault;
		take && fc inside {6'h00, 6'h3f} |=> class_o == 2'h3 ##2 fault_o && busy_o;
	endproperty
	a_fault: assert property (p_fault) else $error("fault code not stopped");
	property p_lp;
		take && fc[5:3] == 3'h4 |=> logic_prod_o && !selective_o;
	endproperty
	a_lp: assert property (p_lp) else $error("product group missed");
	property p_direct;
		rd && kd inside {3'h0, 3'h4, 3'h7} |=> !mem_req_o && !done_o ##1 done_o && !mem_req_o;
	endproperty
	a_direct: assert property (p_direct) else $error("direct operand used storage");
	property p_imm;
		rd && kd == 3'h0 |=> ##1 operand_valid_o && operand_o == {15'h0, $past(instr_i[14:0], 2)};
	endproperty
	a_imm: assert property (p_imm) else $error("immediate operand wrong");
	property p_acc;
		rd && kd == 3'h7 |=> ##1 operand_valid_o && operand_o == $past(acc_i);
	endproperty
	a_acc: assert property (p_acc) else $error("accumulator operand wrong");
	property p_st4;
		st && kd == 3'h4 |=> ##1 acc_wr_o && acc_data_o == $past(store_data_i, 2) && !mem_req_o;
	endproperty
	a_st4: assert property (p_st4) else $error("accumulator load wrong");
	property p_st7;
		st && kd == 3'h7 |=> ##1 mem_req_o && mem_we_o && mem_wdata_o == ~$past(store_data_i, 2)
			&& mem_addr_o == $past(instr_i[14:0], 2);
	endproperty
	a_st7: assert property (p_st7) else $error("complement write wrong");
	property p_hold;
		mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o);
	endproperty
	a_hold: assert property (p_hold) else $error("storage request dropped");
	property p_addr;
		rd && kd inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6} |=> ##1 mem_req_o && !mem_we_o
			&& mem_addr_o == $past(instr_i[14:0], 2);
	endproperty
	a_addr: assert property (p_addr) else $error("unmodified address wrong");
endmodule
bind oiu_top oiu_top_assertions u_oiu_top_assertions (.ref_clk_i, .rst_n_i, .start_i, .instr_i,
	.store_data_i, .acc_i, .mem_ack_i, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
	.operand_o, .operand_valid_o, .acc_wr_o, .acc_data_o, .class_o, .logic_prod_o,
	.selective_o, .busy_o, .done_o, .fault_o);
`default_nettype wire

/* File: tb/oiu_mem_model.sv */
// Core storage model with variable answer delay
`timescale 1ns/1ps
`default_nettype none
module oiu_mem_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [14:0] addr_i,
	input wire logic [29:0] wdata_i,
	input wire logic [1:0] delay_i,
	output logic ack_o,
	output logic [29:0] rdata_o
);
	logic [29:0] mem [32768];
	logic [1:0] wait_ff;
	initial begin
		for (int i = 0; i < 32768; i++) begin
			mem[i] = {15'(i) ^ 15'h2b6d, ~15'(i)};
		end
	end
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_o <= 1'b0;
			wait_ff <= 2'h0;
			rdata_o <= 30'h2aaaaaaa;
		end else begin
			ack_o <= 1'b0;
			// Read data valid only beside the answer
			rdata_o <= ~rdata_o;
			if (req_i && !ack_o && wait_ff != 2'h0) begin
				wait_ff <= wait_ff - 2'h1;
			end else if (req_i && !ack_o) begin
				ack_o <= 1'b1;
				wait_ff <= delay_i;
				if (we_i) begin
					mem[addr_i] <= wdata_i;
				end else begin
					rdata_o <= mem[addr_i];
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/test_oiu_top.sv */
// Self-checking bench for the operand interpretation unit
`timescale 1ns/1ps
`default_nettype none
module test_oiu_top;
	logic ref_clk_i, rst_n_i, start_i, wb_valid_i, idx_wr_i, fault_clr_i, mem_ack_i, mem_req_o;
	logic mem_we_o, operand_valid_o, acc_wr_o, aux_wr_o, logic_prod_o, selective_o, busy_o;
	logic done_o, fault_o;
	logic [29:0] instr_i, store_data_i, acc_i, wb_data_i, mem_rdata_i, mem_wdata_o, operand_o;
	logic [29:0] acc_data_o, aux_data_o;
	logic [14:0] idx_data_i, mem_addr_o;
	logic [14:0] idx [1:7];
	logic [5:0] fl [4] = '{6'h08, 6'h0d, 6'h2c, 6'h27};
	logic [2:0] idx_sel_i, cond_o;
	logic [1:0] class_o, dly;
	int n_errors, num_checks, cyc;
	oiu_top u_oiu_top (.ref_clk_i, .rst_n_i, .start_i, .instr_i, .store_data_i, .acc_i,
		.wb_valid_i, .wb_data_i, .idx_wr_i, .idx_sel_i, .idx_data_i, .fault_clr_i, .mem_ack_i,
		.mem_rdata_i, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .operand_o,
		.operand_valid_o, .acc_wr_o, .acc_data_o, .aux_wr_o, .aux_data_o, .class_o, .cond_o,
		.logic_prod_o, .selective_o, .busy_o, .done_o, .fault_o);
	oiu_mem_model u_oiu_mem_model (.clk_i(ref_clk_i), .rst_n_i, .req_i(mem_req_o),
		.we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .delay_i(dly),
		.ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
	always #2.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		wb_valid_i <= operand_valid_o && class_o == 2'h2;
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			$display("BAD timeout exp done got hang");
			wrap_up();
		end
	end
	function automatic logic [14:0] ocadd(input logic [14:0] a, input logic [14:0] b);
		logic [15:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[14:0] + {14'h0, s[15]};
	endfunction
	function automatic logic [1:0] cls(input logic [5:0] f);
		if (f inside {6'h00, 6'h3f}) return 2'h3;
		if (f inside {[6'h0c:6'h0f], 6'h1a, 6'h1b, 6'h27}) return 2'h1;
		return f inside {6'h14, 6'h15, [6'h1c:6'h1f], [6'h24:6'h26], [6'h2c:6'h2f]} ? 2'h2 : 2'h0;
	endfunction
	function automatic logic [29:0] rd_op(input logic [2:0] k, input logic [14:0] y,
		input logic [29:0] z, input logic [29:0] a);
		logic [14:0] h;
		h = k[1] ? z[29:15] : (k[0] ? z[14:0] : y);
		if (k == 3'h3) return z;
		if (k == 3'h7) return a;
		return {{15{k[2] & h[14]}}, h};
	endfunction
	function automatic logic [29:0] wr_w(input logic [2:0] k, input logic [29:0] x,
		input logic [29:0] o, input logic c);
		logic [14:0] h;
		h = c ? ~x[14:0] : x[14:0];
		case (k)
			3'h1, 3'h5: return {o[29:15], h};
			3'h2, 3'h6: return {h, o[14:0]};
			3'h3: return x;
			3'h7: return c ? ~x : o;
			default: return o;
		endcase
	endfunction
	task automatic chk(input string what, input logic [29:0] exp, input logic [29:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic run(input logic [29:0] ins);
		logic [2:0] k;
		logic [14:0] a;
		logic [29:0] old, sd, ac, wb, op, ax, aq;
		logic [1:0] c;
		int na, nq;
		k = ins[20:18];
		c = cls(ins[29:24]);
		a = ins[17:15] == 3'h0 ? ins[14:0] : ocadd(ins[14:0], idx[ins[17:15]]);
		old = u_oiu_mem_model.mem[a];
		{sd, ac, wb} = {30'($urandom), 30'($urandom), 30'($urandom)};
		op = 'x;
		na = 0;
		nq = 0;
		{instr_i, store_data_i, acc_i, wb_data_i, start_i} <= {ins, sd, ac, wb, 1'b1};
		dly <= 2'($urandom);
		@(posedge ref_clk_i);
		start_i <= 1'b0;
		@(posedge ref_clk_i);
		chk("class", {23'h0, c, ins[23:21], ins[29:27] == 3'h4, ins[29:27] == 3'h5},
			{23'h0, class_o, cond_o, logic_prod_o, selective_o});
		for (int n = 0; n < 80; n++) begin
			if (operand_valid_o) op = operand_o;
			if (aux_wr_o) {na, ax} = {na + 1, aux_data_o};
			if (acc_wr_o) {nq, aq} = {nq + 1, acc_data_o};
			if (done_o || fault_o) break;
			@(posedge ref_clk_i);
		end
		if (c == 2'h3) begin
			chk("fault", 30'h1, {29'h0, fault_o});
			fault_clr_i <= 1'b1;
			@(posedge ref_clk_i);
			fault_clr_i <= 1'b0;
			@(posedge ref_clk_i);
			chk("fault_left", 30'h0, {28'h0, fault_o, busy_o});
		end else begin
			chk("done", 30'h1, {29'h0, done_o});
			if (c != 2'h1) chk("operand", rd_op(k, a, old, ac), op);
			chk("pulses", {28'h0, c == 2'h1 && k == 3'h0, c == 2'h1 && k == 3'h4},
				{28'h0, na == 1, nq == 1});
			if (na == 1) chk("aux", sd, ax);
			if (nq == 1) chk("acc", sd, aq);
			if (c == 2'h2) chk("repl_mem", wr_w(k, wb, old, 1'b0), u_oiu_mem_model.mem[a]);
			else chk("mem", c == 2'h1 ? wr_w(k, sd, old, k[2]) : old, u_oiu_mem_model.mem[a]);
		end
		$display("test %h errors %0d", ins, n_errors);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		{ref_clk_i, rst_n_i, start_i, wb_valid_i, idx_wr_i, fault_clr_i} = 6'h0;
		{instr_i, store_data_i, acc_i, wb_data_i} = '0;
		{idx_sel_i, idx_data_i, dly} = '0;
		void'($urandom(77540));
		repeat (12) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		// Register zero write must be ignored
		for (int i = 7; i >= 0; i--) begin
			logic [14:0] v;
			v = i == 1 ? 15'h0 : (i == 7 ? 15'h7fff : 15'($urandom));
			if (i > 0) idx[i] = v;
			@(posedge ref_clk_i);
			{idx_wr_i, idx_sel_i, idx_data_i} <= {1'b1, 3'(i), v};
		end
		@(posedge ref_clk_i);
		idx_wr_i <= 1'b0;
		foreach (fl[j]) for (int k = 0; k < 8; k++) run({fl[j], 3'h2, 3'(k), 3'h0, 15'h4a5a});
		for (int f = 32; f < 48; f++) run({6'(f), 3'h5, 3'h6, 3'h2, 15'h7001});
		run({6'h08, 3'h0, 3'h3, 3'h1, 15'h0});
		run({6'h08, 3'h0, 3'h0, 3'h7, 15'h1});
		run({6'h00, 24'h0});
		run({6'h3f, 24'h123456});
		repeat (150) run(30'($urandom));
		wrap_up();
	end
endmodule
`default_nettype wire
